// [design/pp_read_pkg.sv]
// How it works
// - Each cycle opens with the address on all sixteen lines and the latch strobe active for two peripheral clocks.
// - The full address stays on the lines one peripheral clock after the latch strobe ends.
// - The low eight lines are released within one peripheral clock after the latch strobe ends.
// - The read strobe goes active two peripheral clocks after the latch strobe ends.
// - The read strobe stays active for the programmed duration field times the peripheral clock period, or one period for a zero field.
// - A configured hold cycle adds one peripheral clock after the read strobe rises.
// - The next latch strobe waits for flash time plus hold time plus one peripheral clock after the read strobe rises.
// - At least hold time plus one peripheral clock separates a read strobe rise from its next fall.
// - No new address is driven until flash time, hold time and one peripheral clock have passed.
// - The upper eight address lines stay driven for the hold time after the read strobe rises.
// - The peripheral clock is half the core clock and all counts are in peripheral clocks.
// - The latch strobe is active high after reset and software may make it active low.
package pp_read_pkg;

  // ==========================================================
  // Register map
  // ==========================================================
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] ADDR_OFFSET = 4'h4;
  localparam logic [3:0] STATUS_OFFSET = 4'h8;
  localparam logic [3:0] DATA_OFFSET = 4'hC;

  // Control field positions
  localparam int CTRL_START_BIT = 0;
  localparam int DUR_LO_BIT = 1;
  localparam int DUR_HI_BIT = 5;
  localparam int HOLD_BIT = 6;
  localparam int FLASH_BIT = 7;
  localparam int ALE_LOW_BIT = 8;
  localparam logic [8:0] CTRL_RESET = 9'h004;

  // Status field positions
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;

  // ==========================================================
  // Timing in peripheral clocks
  // ==========================================================
  localparam logic [4:0] ALE_PCLKS = 5'h02;
  localparam logic [4:0] ALE_TO_RD_PCLKS = 5'h02;
  localparam logic [4:0] FLASH_PCLKS = 5'h07;
  localparam logic [4:0] HOLD_PCLKS = 5'h01;
  localparam logic [4:0] ADDR_GAP_PCLKS = 5'h01;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_ALE   = 6'b000010,
    ST_SETUP = 6'b000100,
    ST_READ  = 6'b001000,
    ST_HOLD  = 6'b010000,
    ST_GAP   = 6'b100000
  } rd_state_t;

endpackage

// [design/pclk_divider.sv]
// Peripheral clock enable at half the core clock rate
module pclk_divider
  import pp_read_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  output logic pclkTick
);

  logic phase_r;

  // ==========================================================
  // Divide by two
  // ==========================================================
  // Tick marks the last core clock of each peripheral clock
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      phase_r <= 1'b0;
    else
      phase_r <= ~phase_r;
  end

  assign pclkTick = phase_r;

endmodule

// [design/pp_byte_read.sv]
// Byte-wide read sequencer for the multiplexed parallel port
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
module pp_byte_read
  import pp_read_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] adIn,
  output logic [15:0] adOut,
  output logic [15:0] adOe,
  output logic ale,
  output logic rdN
);

  // ==========================================================
  // Register state
  // ==========================================================
  logic [8:0] portCtrl_r;
  logic [15:0] addr_r;
  logic [7:0] rdData_r;
  logic done_r;
  logic startPulse;
  logic pclkTick;
  logic [15:0] adInS1_r;
  logic [15:0] adInS2_r;
  rd_state_t state_r;
  logic [4:0] cnt_r;
  logic [4:0] cntEnd;
  logic aleAct;
  logic lowOe;
  logic highOe;
  logic aw_r;
  logic w_r;
  logic [3:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic [4:0] duration;
  logic [4:0] gapLen;
  logic startPend_r;
  logic rdPrev_r;
  logic capNow_r;
  logic busy;

  pclk_divider u_div
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pclkTick(pclkTick)
  );

  assign duration = portCtrl_r[DUR_HI_BIT:DUR_LO_BIT];

  // Pins cross in from outside, two flops first
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      adInS1_r <= 16'h0000;
      adInS2_r <= 16'h0000;
    end
    else
    begin
      adInS1_r <= adIn;
      adInS2_r <= adInS1_r;
    end
  end

  // ==========================================================
  // AXI4-Lite write side
  // ==========================================================
  // Address and data are caught independently, in any order
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      aw_r <= 1'b0;
      w_r <= 1'b0;
      awAddr_r <= 4'h0;
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_r <= 1'b1;
        awAddr_r <= s_axi_awaddr[3:0];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (aw_r && w_r)
      begin
        aw_r <= 1'b0;
        w_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  assign s_axi_awready = !aw_r && !s_axi_bvalid;
  assign s_axi_wready = !w_r && !s_axi_bvalid;
  assign s_axi_bresp = 2'h0;

  // Start bit is a self-clearing strobe, ignored by the sequencer outside idle
  assign startPulse = aw_r && w_r && (awAddr_r == CTRL_OFFSET)
    && wStrb_r[0] && wData_r[CTRL_START_BIT];

  // Control and address registers; fields held fixed during a cycle
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      portCtrl_r <= CTRL_RESET;
      addr_r <= 16'h0000;
    end
    else if (aw_r && w_r && state_r == ST_IDLE)
    begin
      if (awAddr_r == CTRL_OFFSET)
      begin
        if (wStrb_r[0])
          portCtrl_r[7:1] <= wData_r[7:1];
        if (wStrb_r[1])
          portCtrl_r[ALE_LOW_BIT] <= wData_r[ALE_LOW_BIT];
      end
      else if (awAddr_r == ADDR_OFFSET)
      begin
        if (wStrb_r[0])
          addr_r[7:0] <= wData_r[7:0];
        if (wStrb_r[1])
          addr_r[15:8] <= wData_r[15:8];
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read side
  // ==========================================================
  // One cycle answer; unmapped offsets read zero with OKAY
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      // Full address decoded, so higher offsets never alias the map
      unique case (s_axi_araddr)
        {28'h0000000, CTRL_OFFSET}:
          s_axi_rdata <= {23'h000000, portCtrl_r[8:1], 1'b0};
        {28'h0000000, ADDR_OFFSET}: s_axi_rdata <= {16'h0000, addr_r};
        {28'h0000000, STATUS_OFFSET}:
          s_axi_rdata <= {30'h00000000, done_r, busy};
        {28'h0000000, DATA_OFFSET}: s_axi_rdata <= {24'h000000, rdData_r};
        default: s_axi_rdata <= 32'h00000000;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rresp = 2'h0;

  // Busy spans the pending start and the late data capture, so a poll
  // never sees idle before the byte has landed
  assign busy = (state_r != ST_IDLE) || startPend_r || (rdN && !rdPrev_r)
    || capNow_r;

  // ==========================================================
  // Read cycle sequencer
  // ==========================================================
  // Gap after the strobe rises: flash time plus the extra address
  // clock; the hold clock is its own state
  assign gapLen = (portCtrl_r[FLASH_BIT] ? FLASH_PCLKS : 5'h00)
    + ADDR_GAP_PCLKS;

  // Last count of each timed state; a zero duration still reads one
  always_comb
  begin
    cntEnd = 5'h00;
    unique case (state_r)
      ST_ALE: cntEnd = ALE_PCLKS - 5'h01;
      ST_SETUP: cntEnd = ALE_TO_RD_PCLKS - 5'h01;
      ST_READ: cntEnd = (duration == 5'h00) ? 5'h00
        : duration - 5'h01;
      ST_HOLD: cntEnd = HOLD_PCLKS - 5'h01;
      ST_GAP: cntEnd = gapLen - 5'h01;
      default: cntEnd = 5'h00;
    endcase
  end

  // State advances only on peripheral clock boundaries
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_r <= ST_IDLE;
      cnt_r <= 5'h00;
      startPend_r <= 1'b0;
    end
    else if (state_r == ST_IDLE)
    begin
      cnt_r <= 5'h00;
      // Start waits for the tick so the first latch clock is a whole one
      if ((startPulse || startPend_r) && pclkTick)
      begin
        state_r <= ST_ALE;
        startPend_r <= 1'b0;
      end
      else
        startPend_r <= startPulse || startPend_r;
    end
    else if (pclkTick)
    begin
      if (cnt_r != cntEnd)
        cnt_r <= cnt_r + 5'h01;
      else
      begin
        cnt_r <= 5'h00;
        unique case (state_r)
          ST_ALE: state_r <= ST_SETUP;
          ST_SETUP: state_r <= ST_READ;
          ST_READ: state_r <= portCtrl_r[HOLD_BIT] ? ST_HOLD
            : ST_GAP;
          ST_HOLD: state_r <= ST_GAP;
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

  // Pins pass two flops, so the byte seen as the strobe rises is taken
  // two clocks after that edge; earlier would miss a one clock strobe
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      rdPrev_r <= 1'b1;
      capNow_r <= 1'b0;
      rdData_r <= 8'h00;
      done_r <= 1'b0;
    end
    else
    begin
      rdPrev_r <= rdN;
      capNow_r <= rdN && !rdPrev_r;
      if (capNow_r)
      begin
        rdData_r <= adInS2_r[7:0];
        done_r <= 1'b1;
      end
      else if (startPulse)
        done_r <= 1'b0;
    end
  end

  // ==========================================================
  // Pin drive
  // ==========================================================
  // Low lines drive only during the strobe phase; first setup clock
  // keeps the full address, then low lines float
  assign aleAct = (state_r == ST_ALE);
  assign lowOe = aleAct
    || (state_r == ST_SETUP && cnt_r == 5'h00);
  assign highOe = lowOe || state_r == ST_SETUP || state_r == ST_READ
    || state_r == ST_HOLD;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ale <= 1'b0;
      rdN <= 1'b1;
      adOut <= 16'h0000;
      adOe <= 16'h0000;
    end
    else
    begin
      ale <= aleAct ^ portCtrl_r[ALE_LOW_BIT];
      rdN <= !(state_r == ST_READ);
      adOut <= addr_r;
      adOe <= {{8{highOe}}, {8{lowOe}}};
    end
  end

endmodule

// [sim/pp_read_props.sv]
module pp_read_props
  import pp_read_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [15:0] adOut,
  input wire logic [15:0] adOe,
  input wire logic ale,
  input wire logic rdN
);
  timeunit 1ns;
  timeprecision 1ps;
  logic idleAle_r;
  logic aleOn;
  logic [6:0] lowCnt_r;
  // =========================================
  // Strobe timing
  // =========================================
  // Idle level learned with all lines free, so polarity need not be known
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      idleAle_r <= 1'b0;
    else if (adOe == 16'h0000)
      idleAle_r <= ale;
  end
  // Gated by the enables: a polarity change alone is no strobe
  assign aleOn = (ale != idleAle_r) && (adOe != 16'h0000);
  // Read strobe length in core clocks
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      lowCnt_r <= 7'h00;
    else
      lowCnt_r <= rdN ? 7'h00 : lowCnt_r + 7'h01;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_ale_width: assert property ($rose(aleOn) |-> aleOn[*4] ##1 !aleOn)
    else $error("latch strobe width wrong");
  chk_ale_addr: assert property (aleOn |-> adOe == 16'hFFFF)
    else $error("address not driven under latch strobe");
  chk_addr_hold: assert property (
    $fell(aleOn) |-> ($stable(adOut) && adOe == 16'hFFFF)[*2])
    else $error("address not held after latch strobe");
  chk_low_float: assert property ($fell(aleOn) |-> ##2 adOe[7:0] == 8'h00)
    else $error("low lines not released");
  chk_rd_delay: assert property ($fell(aleOn) |-> rdN[*4] ##1 !rdN)
    else $error("read strobe delay wrong");
  chk_rd_lines: assert property (!rdN |-> adOe == 16'hFF00)
    else $error("line enables wrong under read strobe");
  chk_rd_width: assert property (
    $rose(rdN) |-> lowCnt_r[0] == 1'b0 && lowCnt_r >= 7'h02)
    else $error("read strobe not whole peripheral clocks");
  chk_rd_gap: assert property (
    $rose(rdN) |-> (rdN && !aleOn && adOe[7:0] == 8'h00)[*2])
    else $error("gap after read strobe too short");
  cover property ($rose(aleOn));
  cover property ($rose(rdN) && lowCnt_r == 7'h3E);
  cover property ($fell(aleOn) && idleAle_r);
endmodule

bind pp_byte_read pp_read_props i_props (.ref_clk, .rst_n, .adOut, .adOe,
  .ale, .rdN);

// [sim/async_mem_model.sv]
module async_mem_model
(
  input wire logic ref_clk,
  input wire logic [15:0] adOut,
  input wire logic [15:0] adOe,
  input wire logic rdN,
  input wire logic lateData,
  output logic [15:0] adIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] addr_r;
  logic [7:0] noise_r = 8'hA5;
  logic [3:0] lowCnt_r = 4'h0;
  logic [7:0] lowByte;
  // =========================================
  // Memory behaviour
  // =========================================
  // Address latched while all lines carry it; free lines toggle
  always @(posedge ref_clk)
  begin
    if (adOe == 16'hFFFF)
      addr_r <= adOut;
    noise_r <= ~noise_r;
    lowCnt_r <= rdN ? 4'h0 : lowCnt_r + 4'h1;
  end
  // Slow mode answers one peripheral clock into the strobe
  assign lowByte = (!rdN && (!lateData || lowCnt_r >= 4'h2)) ?
    (addr_r[7:0] ^ addr_r[15:8] ^ 8'h5A) : noise_r;
  assign adIn = (adOe & adOut) | (~adOe & {noise_r, lowByte});
endmodule

// [sim/tb.sv]
module tb
  import pp_read_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, lateData = 1'b0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, r;
  logic [15:0] adIn, adOut, adOe;
  logic ale, rdN, aleQ = 1'b0, rdQ = 1'b1, aleIdle = 1'b0, aleGo;
  int badCount = 0, nChecks = 0, cyc = 0, lowCnt = 0, gapCnt = 0, hiCnt = 0;
  int lastGap = 0, gapMin = 0;
  pp_byte_read i_dut (.ref_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .adIn, .adOut, .adOe, .ale, .rdN);
  async_mem_model i_mem (.ref_clk, .adOut, .adOe, .rdN, .lateData, .adIn);
  // =========================================
  // Clock, watchdog and strobe monitor
  // =========================================
  always #4 ref_clk = ~ref_clk;
  // Latch start judged against its idle level, so either polarity works
  assign aleGo = (adOe != 16'h0) && (ale != aleIdle) && (aleQ == aleIdle);
  // Strobe counts restart at each latch start; generous cycle ceiling
  always @(posedge ref_clk)
  begin
    aleQ <= ale;
    rdQ <= rdN;
    if (adOe == 16'h0)
      aleIdle <= ale;
    gapCnt <= (rdN && !rdQ) ? 1 : gapCnt + 1;
    lowCnt <= aleGo ? 0 : lowCnt + (rdN ? 0 : 1);
    hiCnt <= aleGo ? 0 : hiCnt + ((rdN && adOe[15] && lowCnt != 0) ? 1 : 0);
    if (aleGo)
      lastGap <= gapCnt;
    cyc++;
    if (cyc == 20000)
    begin
      badCount++;
      closeOut();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp)
    begin
      badCount++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chkMin(input int got, input int lo);
    nChecks++;
    if ((got >= lo) !== 1'b1)
    begin
      badCount++;
      $display("unexpected at %0t: %0d below %0d", $time, got, lo);
    end
  endtask
  task automatic axiWr(input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axiRd(input logic [31:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask
  // One whole byte read: program, start, poll, then judge pins and data
  task automatic runRead(input logic [15:0] a, input logic [4:0] d,
    input logic h, input logic f, input logic lo);
    int n;
    n = 0;
    axiWr({28'h0, ADDR_OFFSET}, {16'h0, a});
    axiWr({28'h0, CTRL_OFFSET}, {23'h0, lo, f, h, d, 1'b1});
    do
    begin
      axiRd({28'h0, STATUS_OFFSET}, r);
      n++;
    end
    while (r[STAT_BUSY_BIT] !== 1'b0 && n < 100);
    chk({30'h0, r[1:0]}, 32'h2);
    chkMin(lastGap, gapMin);
    chk(32'(lowCnt), 32'(2 * (d == 5'h00 ? 1 : d)));
    chk(32'(hiCnt), 32'(2 * h));
    axiRd({28'h0, DATA_OFFSET}, r);
    chk(r, {24'h0, a[7:0] ^ a[15:8] ^ 8'h5A});
    gapMin = 2 * (7 * f + h + 1);
  endtask
  task automatic closeOut();
    $display("checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // =========================================
  // Main sequence
  // =========================================
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk({14'h0, ale, rdN, adOe}, 32'h00010000);
    axiRd({28'h0, CTRL_OFFSET}, r);
    chk(r, {23'h0, CTRL_RESET});
    axiRd(32'h00000010, r);
    chk(r, 32'h0);
    runRead(16'h3CA5, 5'h00, 1'b0, 1'b0, 1'b0);
    runRead(16'h1234, 5'h01, 1'b1, 1'b0, 1'b0);
    runRead(16'hFF0F, 5'h1F, 1'b0, 1'b1, 1'b0);
    runRead(16'h0001, 5'h02, 1'b1, 1'b1, 1'b0);
    lateData <= 1'b1;
    runRead(16'h8000, 5'h06, 1'b0, 1'b0, 1'b0);
    lateData <= 1'b0;
    axiWr({28'h0, CTRL_OFFSET}, 32'h00000104);
    repeat (3) @(posedge ref_clk);
    chk({31'h0, ale}, 32'h1);
    runRead(16'h00C3, 5'h03, 1'b0, 1'b0, 1'b1);
    closeOut();
  end
endmodule
